// ==== verilog/pes_defines.svh ====
// Purpose: offsets, field positions and codes of the event-select block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: included by bare name
`ifndef PES_DEFINES_SVH
`define PES_DEFINES_SVH

// ******************************
// register map (byte addresses)
// ******************************
`define PES_SEL_BASE 8'h00
`define PES_CFG_BASE 8'h10
`define PES_CNT_BASE 8'h30
`define PES_MAP_END 8'h50

// ******************************
// field positions
// ******************************
`define PES_CODE_HI 30
`define PES_CODE_LO 25
`define PES_MASK_HI 24
`define PES_MASK_LO 9
`define PES_CSEL_HI 15
`define PES_CSEL_LO 13
`define PES_CEN_BIT 12

// ******************************
// writable bits and reset values
// ******************************
`define PES_SEL_WMASK 32'h7ffffe00
`define PES_CFG_WMASK 32'h0000f000
`define PES_SEL_RST 32'h00000000
`define PES_CFG_RST 32'h00000000
`define PES_CNT_RST 32'h00000000

// ******************************
// event and select codes
// ******************************
`define PES_CODE_COMBINE 6'h05
`define PES_CSEL_COMBINE 3'h5
`define PES_CODE_B2B 6'h16
`define PES_CODE_BNR 6'h08
`define PES_CODE_SNOOP 6'h06
`define PES_CODE_RESP 6'h04
`define PES_CSEL_BUS 3'h3

// ******************************
// legal sub-event bits
// ******************************
`define PES_LEGAL_B2B 16'h007e
`define PES_LEGAL_BNR 16'h0007
`define PES_LEGAL_SNOOP 16'h00c4
`define PES_LEGAL_RESP 16'h0306

// front-bus events may be left out of a model
`define PES_BUS_EVENTS_EN 1'b1

`endif

// ==== verilog/pes_pkg.sv ====
// Purpose: types shared by the event-select block
// Assumes: nothing beyond the defines header
// Notes: occurrence inputs are one-cycle pulses
package pes_pkg;

    typedef logic [31:0] pes_word_type;

    typedef struct packed {
        logic evict_any;
        logic evict_none_free;
    } pes_combine_type;

    typedef struct packed {
        logic [15:0] b2b;
        logic [15:0] bnr;
        logic [15:0] snoop;
        logic [15:0] resp;
    } pes_bus_type;

endpackage

// ==== verilog/pes_event_select.sv ====
// Purpose: event selection and counting for combine-buffer and front-bus events
// Assumes: event inputs synchronous to pclk, one cycle per occurrence
// Notes: eight counters, numbered 0-3 (front bus) and 8-11 (data access)
// Notes: counters wrap silently; there is no overflow or interrupt logic
`timescale 1ns/10ps
`include "pes_defines.svh"

module pes_event_select
    import pes_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event occurrences
    input wire pes_combine_type combine_buffer_event,
    input wire pes_bus_type bus_event,
    // counter activity
    output logic [7:0] count_tick
);

    // ******************************
    // register storage
    // ******************************
    // index 0,1: front_bus_select_first/second; 2,3: data_access_select_first/second
    pes_word_type sel_q [4];
    pes_word_type sel_d [4];
    // counter config and value, slot k: 0-3 -> counters 0-3, 4-7 -> counters 8-11
    pes_word_type cfg_q [8];
    pes_word_type cfg_d [8];
    pes_word_type cnt_q [8];
    pes_word_type cnt_d [8];
    pes_word_type rdata_q;
    pes_word_type rdata_d;
    logic err_q;
    logic err_d;
    logic [7:0] tick_q;
    logic [7:0] tick_d;
    // hit is combinational; tick and counters register it together
    logic [7:0] hit;

    // ******************************
    // bus decode
    // ******************************
    logic setup_ph;
    logic access_ph;
    logic [5:0] widx;
    logic in_sel;
    logic in_cfg;
    logic in_cnt;
    logic mapped;

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign widx = paddr[7:2];
    assign in_sel = (paddr >= `PES_SEL_BASE) && (paddr < `PES_CFG_BASE);
    assign in_cfg = (paddr >= `PES_CFG_BASE) && (paddr < `PES_CNT_BASE);
    assign in_cnt = (paddr >= `PES_CNT_BASE) && (paddr < `PES_MAP_END);
    // misaligned addresses are refused even inside a window
    assign mapped = (paddr[1:0] == 2'h0) && (in_sel || in_cfg || in_cnt);

    // zero wait states: every access ends in its first access cycle
    assign pready = 1'b1;
    assign prdata = rdata_q;
    assign pslverr = err_q && access_ph;
    assign count_tick = tick_q;

    // ******************************
    // event matching per counter
    // ******************************
    // each slot decodes its pair member itself; slots 2k and 2k+1 share one select register
    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_slot
            logic [5:0] code;
            logic [15:0] mask;
            logic [2:0] csel;
            logic cen;
            logic [15:0] occ;
            logic [15:0] legal;
            logic code_ok;
            pes_word_type esel;

            // pair member: counters 0,1/8,9 use the first, 2,3/10,11 the second
            assign esel = sel_q[k / 2];
            assign code = esel[`PES_CODE_HI:`PES_CODE_LO];
            assign mask = esel[`PES_MASK_HI:`PES_MASK_LO];
            assign csel = cfg_q[k][`PES_CSEL_HI:`PES_CSEL_LO];
            assign cen = cfg_q[k][`PES_CEN_BIT];

            always_comb begin
                occ = 16'h0000;
                legal = 16'h0000;
                code_ok = 1'b0;
                if (k >= 4) begin
                    code_ok = (code == `PES_CODE_COMBINE) && (csel == `PES_CSEL_COMBINE);
                    occ = {14'h0000, combine_buffer_event.evict_none_free,
                           combine_buffer_event.evict_any};
                    legal = 16'h0003;
                end else if (`PES_BUS_EVENTS_EN && (csel == `PES_CSEL_BUS)) begin
                    code_ok = 1'b1;
                    case (code)
                        `PES_CODE_B2B: begin
                            occ = bus_event.b2b;
                            legal = `PES_LEGAL_B2B;
                        end
                        `PES_CODE_BNR: begin
                            occ = bus_event.bnr;
                            legal = `PES_LEGAL_BNR;
                        end
                        `PES_CODE_SNOOP: begin
                            occ = bus_event.snoop;
                            legal = `PES_LEGAL_SNOOP;
                        end
                        `PES_CODE_RESP: begin
                            occ = bus_event.resp;
                            legal = `PES_LEGAL_RESP;
                        end
                        default: begin
                            code_ok = 1'b0;
                        end
                    endcase
                end
            end

            assign hit[k] = cen && code_ok && (|(occ & mask & legal));
        end
    endgenerate

    // ******************************
    // access decode
    // ******************************
    logic [5:0] cidx;
    logic [5:0] nidx;
    logic wr_sel;
    logic wr_cfg;
    logic wr_cnt;

    // slot index inside the config and counter windows
    assign cidx = widx - 6'(`PES_CFG_BASE >> 2);
    assign nidx = widx - 6'(`PES_CNT_BASE >> 2);
    // writes land only at the edge that completes the access
    // the three windows never overlap, so one strobe at most is high
    assign wr_sel = access_ph && pwrite && mapped && in_sel;
    assign wr_cfg = access_ph && pwrite && mapped && in_cfg;
    assign wr_cnt = access_ph && pwrite && mapped && in_cnt;

    // ******************************
    // apb read response
    // ******************************
    // captured in the setup cycle, so prdata stands for the whole access
    always_comb begin
        rdata_d = rdata_q;
        err_d = err_q;
        if (setup_ph) begin
            // unmapped or misaligned: read 0, pslverr in the access cycle
            err_d = !mapped;
            rdata_d = 32'h00000000;
            if (mapped && in_sel) begin
                rdata_d = sel_q[widx[1:0]];
            end else if (mapped && in_cfg) begin
                rdata_d = cfg_q[cidx[2:0]];
            end else if (mapped && in_cnt) begin
                rdata_d = cnt_q[nidx[2:0]];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // ******************************
    // event select registers
    // ******************************
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sel_d[i] = sel_q[i];
        end
        // bits outside code and mask are dropped, so they read 0
        if (wr_sel) begin
            sel_d[widx[1:0]] = pwdata & `PES_SEL_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                sel_q[i] <= `PES_SEL_RST;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                sel_q[i] <= sel_d[i];
            end
        end
    end

    // ******************************
    // counter config registers
    // ******************************
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            cfg_d[i] = cfg_q[i];
        end
        // only select and enable are kept
        if (wr_cfg) begin
            cfg_d[cidx[2:0]] = pwdata & `PES_CFG_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                cfg_q[i] <= `PES_CFG_RST;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                cfg_q[i] <= cfg_d[i];
            end
        end
    end

    // ******************************
    // counters
    // ******************************
    // counters wrap at 32 bits; nothing flags an overflow
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            cnt_d[i] = hit[i] ? cnt_q[i] + 32'h00000001 : cnt_q[i];
        end
        // software preset wins over a same-cycle increment
        if (wr_cnt) begin
            cnt_d[nidx[2:0]] = pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                cnt_q[i] <= `PES_CNT_RST;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                cnt_q[i] <= cnt_d[i];
            end
        end
    end

    // ******************************
    // counter activity
    // ******************************
    // tick shows the increment one cycle after the occurrence
    always_comb begin
        tick_d = hit;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 8'h00;
        end else begin
            tick_q <= tick_d;
        end
    end

endmodule // pes_event_select

// ==== test/pes_event_select_properties.sv ====
// Purpose: port checks of the event-select block
// Assumes: one clock domain, async active-low reset
// Notes: bound at the foot of this file
`timescale 1ns/10ps
`include "pes_defines.svh"
module pes_event_select_properties
    import pes_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // events
    input wire pes_combine_type combine_buffer_event,
    input wire pes_bus_type bus_event,
    input wire logic [7:0] count_tick
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic bus_legal;
    // illegal sub-event bits must never reach a counter
    assign bus_legal = |(bus_event & {`PES_LEGAL_B2B, `PES_LEGAL_BNR,
        `PES_LEGAL_SNOOP, `PES_LEGAL_RESP});
    // ****
    // properties
    // ****
    sequence access_s;
        psel && penable;
    endsequence
    sequence bad_s;
        access_s ##0 (paddr >= `PES_MAP_END || paddr[1:0] != 2'h0);
    endsequence
    chk_ready_always: assert property (pready)
        else $error("pready low");
    chk_err_bad_addr: assert property (bad_s |-> pslverr)
        else $error("no error on bad address");
    chk_err_only_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    chk_err_good_addr: assert property
        (access_s ##0 (paddr < `PES_MAP_END && paddr[1:0] == 2'h0) |-> !pslverr)
        else $error("error on mapped address");
    chk_read_bad_zero: assert property (bad_s ##0 !pwrite |-> prdata == 32'h0)
        else $error("bad read not zero");
    chk_bus_slot_cause: assert property (!bus_legal |=> count_tick[3:0] == 4'h0)
        else $error("bus slot ticked without bus event");
    chk_combine_slot_cause: assert property
        (combine_buffer_event == 2'b00 |=> count_tick[7:4] == 4'h0)
        else $error("data slot ticked without combine event");
    chk_tick_after_reset: assert property ($rose(presetn) |-> count_tick == 8'h0)
        else $error("tick right after reset");
endmodule // pes_event_select_properties

bind pes_event_select pes_event_select_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .combine_buffer_event(combine_buffer_event),
    .bus_event(bus_event), .count_tick(count_tick));

// ==== test/pes_event_select_bench.sv ====
// Purpose: self-checking bench of the event-select block
// Assumes: zero-wait apb slave, one-cycle event pulses
// Notes: reset and mask expectations built from the defines; counts and ticks are literals
`timescale 1ns/10ps
`include "pes_defines.svh"
module pes_event_select_bench
    import pes_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00, count_tick;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    pes_combine_type comb = '0;
    pes_bus_type bus = '0;
    int miscompares = 0, n_compared = 0;
    always #25 pclk = ~pclk;
    pes_event_select DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .combine_buffer_event(comb), .bus_event(bus),
        .count_tick(count_tick));
    // ****
    // shared tasks
    // ****
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // request stands until pready is sampled high at a rising edge
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) miscompares++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp, "read");
    endtask
    task automatic pulse(input pes_combine_type c, input pes_bus_type b, input logic [7:0] t);
        @(posedge pclk);
        comb <= c;
        bus <= b;
        @(posedge pclk);
        comb <= '0;
        bus <= '0;
        // tick launched at the sampling edge, read while it stands
        @(posedge pclk);
        check({24'h0, count_tick}, {24'h0, t}, "tick");
        @(posedge pclk);
        check({24'h0, count_tick}, 32'h0, "tick end");
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task automatic test_regs();
        rdchk(8'h00, `PES_SEL_RST);
        rdchk(8'h30, `PES_CNT_RST);
        apb(1'b1, 8'h0c, 32'hffffffff);
        rdchk(8'h0c, `PES_SEL_WMASK);
        apb(1'b1, 8'h1c, 32'hffffffff);
        rdchk(8'h1c, `PES_CFG_WMASK);
        rdchk(`PES_MAP_END, 32'h0);
        check({31'h0, er}, 32'h1, "unmapped error");
        apb(1'b1, 8'h02, 32'hffffffff);
        check({31'h0, er}, 32'h1, "misaligned error");
        rdchk(8'h00, `PES_SEL_RST);
        $display("test_regs done");
    endtask
    task automatic test_combine();
        apb(1'b1, 8'h08, {1'b0, `PES_CODE_COMBINE, 16'h0001, 9'h0});
        apb(1'b1, 8'h0c, {1'b0, `PES_CODE_COMBINE, 16'h0002, 9'h0});
        apb(1'b1, 8'h00, {1'b0, `PES_CODE_COMBINE, 16'h0001, 9'h0});
        apb(1'b1, 8'h10, {16'h0, `PES_CSEL_COMBINE, 1'b1, 12'h0});
        apb(1'b1, 8'h20, {16'h0, `PES_CSEL_COMBINE, 1'b1, 12'h0});
        apb(1'b1, 8'h24, {16'h0, `PES_CSEL_BUS, 1'b1, 12'h0});
        apb(1'b1, 8'h28, {16'h0, `PES_CSEL_COMBINE, 1'b1, 12'h0});
        apb(1'b1, 8'h1c, 32'h0);
        pulse(2'b10, '0, 8'h10);
        pulse(2'b11, '0, 8'h50);
        pulse(2'b00, '1, 8'h00);
        rdchk(8'h40, 32'h2);
        rdchk(8'h48, 32'h1);
        rdchk(8'h44, 32'h0);
        $display("test_combine done");
    endtask
    task automatic test_bus();
        logic [5:0] code [4] = '{`PES_CODE_B2B, `PES_CODE_BNR, `PES_CODE_SNOOP, `PES_CODE_RESP};
        logic [15:0] ok [4] = '{`PES_LEGAL_B2B, `PES_LEGAL_BNR, `PES_LEGAL_SNOOP, `PES_LEGAL_RESP};
        pes_bus_type ev;
        apb(1'b1, 8'h10, {16'h0, `PES_CSEL_BUS, 1'b1, 12'h0});
        apb(1'b1, 8'h18, {16'h0, `PES_CSEL_BUS, 1'b1, 12'h0});
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h00, {1'b0, code[i], ok[i], 9'h0});
            apb(1'b1, 8'h30, 32'h0);
            ev = '1;
            ev[63-16*i -: 16] = ~ok[i];
            pulse(2'b00, ev, 8'h00);
            ev = '0;
            ev[63-16*i -: 16] = 16'hffff;
            pulse(2'b00, ev, 8'h01);
            rdchk(8'h30, 32'h1);
        end
        apb(1'b1, 8'h04, {1'b0, `PES_CODE_BNR, 16'h0001, 9'h0});
        pulse(2'b00, {16'h0000, 16'h0001, 32'h00000000}, 8'h04);
        rdchk(8'h38, 32'h1);
        $display("test_bus done");
    endtask
    task automatic test_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(8'h00, `PES_SEL_RST);
        rdchk(8'h20, `PES_CFG_RST);
        rdchk(8'h40, `PES_CNT_RST);
        pulse(2'b11, '1, 8'h00);
        $display("test_reset done");
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_combine();
        test_bus();
        test_reset();
        complete_run();
    end
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end
endmodule // pes_event_select_bench
